// ==== inc/nav_state_pkg.sv ====
// package: constants, layouts and carriers for the navigation state packet framer
package nav_state_pkg;

    // ****************************************
    // packet identity and size
    // ****************************************
    localparam logic [7:0] PKT_ID_CODE = 8'h14;
    localparam logic [7:0] PKT_LEN_BYTES = 8'h64;
    localparam int PAY_WORDS = 25;
    localparam int VAL_FIRST_WORD = 3;

    // ****************************************
    // register offsets; payload words mirror their byte offsets
    // ****************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SECONDS = 8'h04;
    localparam logic [7:0] OFS_MICROS = 8'h08;
    localparam logic [7:0] OFS_VAL_FIRST = 8'h0C;
    localparam logic [7:0] OFS_ACCEL_X = 8'h30;
    localparam logic [7:0] OFS_GFORCE = 8'h3C;
    localparam logic [7:0] OFS_RATE_X = 8'h4C;
    localparam logic [7:0] OFS_RATE_Z = 8'h54;
    localparam logic [7:0] OFS_SD_LAT = 8'h58;
    localparam logic [7:0] OFS_VAL_LAST = 8'h60;
    localparam logic [7:0] OFS_CTRL = 8'h80;
    localparam logic [7:0] OFS_STAT = 8'h84;

    // ctrl and stat fields
    localparam int CTRL_SEND_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVF_BIT = 1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int MICROSECOND_NS = 1000;
    localparam int CYC_PER_US = (MICROSECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] MICROS_MAX = 32'h000F423F;

    // ****************************************
    // status word layouts, bit 15 first
    // ****************************************
    typedef enum logic [2:0] {
        FIX_NONE, FIX_2D, FIX_3D, FIX_SBAS, FIX_DIFF, FIX_PPP, FIX_RTK_FLOAT, FIX_RTK_FIXED
    } fix_t;

    typedef struct packed {
        logic out_overflow;
        logic antenna_fault;
        logic high_volt;
        logic log_error;
        logic max_temp;
        logic min_temp;
        logic press_over;
        logic mag_over;
        logic gyro_over;
        logic accel_over;
        logic sat_fail;
        logic press_fail;
        logic mag_fail;
        logic gyro_fail;
        logic accel_fail;
        logic sys_fail;
    } health_t;

    typedef struct packed {
        logic ext_heading;
        logic ext_velocity;
        logic ext_position;
        logic atmos_alt;
        logic vel_heading;
        logic dual_ant;
        logic sat_enabled;
        logic event2;
        logic event1;
        fix_t fix;
        logic utc_init;
        logic heading_init;
        logic nav_init;
        logic orient_init;
    } filter_t;

    // ****************************************
    // input and output carriers
    // ****************************************
    typedef struct packed {
        logic sys_fail;
        logic accel_fail;
        logic gyro_fail;
        logic mag_fail;
        logic press_fail;
        logic sat_fail;
        logic accel_over;
        logic gyro_over;
        logic mag_over;
        logic press_over;
        logic min_temp;
        logic max_temp;
        logic log_error;
        logic high_volt;
        logic ant1_open;
        logic ant1_short;
        logic ant2_open;
        logic ant2_short;
    } sense_t;

    typedef struct packed {
        logic orient_init;
        logic nav_init;
        logic heading_init;
        logic utc_init;
        logic sat_enabled;
        logic dual_ant;
        logic vel_heading;
        logic atmos_alt;
        logic ext_position;
        logic ext_velocity;
        logic ext_heading;
    } nav_flags_t;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } tx_byte_t;

endpackage : nav_state_pkg

// ==== design/nav_state_framer.sv ====
// design: navigation state packet framer with its output byte fifo
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// byte fifo, registered output stage
// ****************************************
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("byte_fifo depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic [WIDTH-1:0] next_out_data;
    logic next_out_valid, push, pop;

    always_comb begin
        in_ready = (count != DEPTH[AW:0]);
        push = in_valid && in_ready;
        pop = (count != '0) && (!out_valid || out_ready);
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_out_valid = pop || (out_valid && !out_ready);
        next_out_data = pop ? mem[rd_ptr] : out_data;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            out_valid <= next_out_valid;
            out_data <= next_out_data;
        end
    end
endmodule : byte_fifo

// Function
// - packet is id 20, 100 payload bytes, only ever sent, never accepted
// - health word bits 0-5 sensor failures, bits 6-9 over-range, one means true
// - health bit 14 set on open or short at either antenna
// - health bit 12 logging error; bits 10, 11, 13 temperature and voltage alarms
// - health bit 15 reports output data stream overflow
// - filter word bits 0-3 initialised flags, bits 7-8 external events seen
// - filter bit 10 dual antenna heading, bits 9, 11-15 other aiding states
// - filter bits 6..4 carry the 3-bit fix code, bit 6 most significant
// - offset 4 holds whole unix seconds since 1970
// - offset 8 holds microseconds since last second, 0 to 999999
// - body acceleration xyz at offsets 48, 52, 56, g-force at 60
// - angular rates xyz at offsets 76, 80, 84
// - latitude, longitude, height deviations at offsets 88, 92, 96
module nav_state_framer
    import nav_state_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire sense_t SENSE,
    input wire nav_flags_t NAV,
    input wire fix_t FIX,
    input wire logic EVENT1,
    input wire logic EVENT2,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] PKT_ID,
    output logic [7:0] PKT_LEN,
    output logic BUSY
);
    typedef enum logic {ST_IDLE, ST_SEND} state_t;

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("nav_state_framer needs a fifo of at least 2 words");
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [5:0] word_of(input logic [7:0] a);
        return a[7:2];
    endfunction : word_of

    function automatic health_t build_health(input sense_t s, input logic ovf);
        return '{out_overflow: ovf,
                 antenna_fault: s.ant1_open | s.ant1_short | s.ant2_open | s.ant2_short,
                 high_volt: s.high_volt, log_error: s.log_error,
                 max_temp: s.max_temp, min_temp: s.min_temp,
                 press_over: s.press_over, mag_over: s.mag_over, gyro_over: s.gyro_over,
                 accel_over: s.accel_over, sat_fail: s.sat_fail, press_fail: s.press_fail,
                 mag_fail: s.mag_fail, gyro_fail: s.gyro_fail, accel_fail: s.accel_fail,
                 sys_fail: s.sys_fail};
    endfunction : build_health

    function automatic filter_t build_filter(input nav_flags_t n, input fix_t f,
                                             input logic e1, input logic e2);
        return '{ext_heading: n.ext_heading, ext_velocity: n.ext_velocity,
                 ext_position: n.ext_position, atmos_alt: n.atmos_alt,
                 vel_heading: n.vel_heading, dual_ant: n.dual_ant,
                 sat_enabled: n.sat_enabled, event2: e2, event1: e1, fix: f,
                 utc_init: n.utc_init, heading_init: n.heading_init,
                 nav_init: n.nav_init, orient_init: n.orient_init};
    endfunction : build_filter

    // ****************************************
    // input synchronisers, pins only
    // ****************************************
    sense_t sense_s1, sense_s2;
    nav_flags_t nav_s1, nav_s2;
    fix_t fix_s1, fix_s2;
    logic [1:0] ev_s1, ev_s2, ev_s3;
    logic [1:0] ev_edge;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            {sense_s1, sense_s2, nav_s1, nav_s2} <= '0;
            fix_s1 <= FIX_NONE;
            fix_s2 <= FIX_NONE;
            {ev_s1, ev_s2, ev_s3} <= '0;
        end else begin
            {sense_s1, sense_s2, nav_s1, nav_s2} <= {SENSE, sense_s1, NAV, nav_s1};
            fix_s1 <= FIX;
            fix_s2 <= fix_s1;
            {ev_s1, ev_s2, ev_s3} <= {EVENT2, EVENT1, ev_s1, ev_s2};
        end
    end

    assign ev_edge = ev_s2 & ~ev_s3;

    // ****************************************
    // state
    // ****************************************
    state_t state, next_state;
    logic [6:0] idx, next_idx;
    logic [31:0] snap [PAY_WORDS], next_snap [PAY_WORDS];
    logic [31:0] vals [VAL_FIRST_WORD:PAY_WORDS-1], next_vals [VAL_FIRST_WORD:PAY_WORDS-1];
    logic [31:0] seconds, next_seconds, micros, next_micros;
    logic [7:0] tick, next_tick;
    logic auto_mode, next_auto_mode;
    logic ovf, next_ovf, ev1, next_ev1, ev2, next_ev2;
    logic [31:0] next_rdata, cur_word;
    logic next_busy, send_req, start, second_roll;
    health_t health;
    filter_t filter;
    tx_byte_t fifo_in, fifo_out;
    logic fifo_in_valid, fifo_in_ready;

    assign health = build_health(sense_s2, ovf);
    assign filter = build_filter(nav_s2, fix_s2, ev1, ev2);

    always_comb begin
        // free-running clock of microseconds and seconds
        second_roll = 1'b0;
        next_tick = tick + 8'h01;
        next_micros = micros;
        next_seconds = seconds;
        if (tick == 8'(CYC_PER_US - 1)) begin
            next_tick = 8'h00;
            if (micros == MICROS_MAX) begin
                next_micros = 32'h00000000;
                next_seconds = seconds + 32'h00000001;
                second_roll = 1'b1;
            end else begin
                next_micros = micros + 32'h00000001;
            end
        end
        // software load of seconds wins over the rollover
        if (WR && ADDR == OFS_SECONDS) begin
            next_seconds = WDATA;
        end
        next_auto_mode = auto_mode;
        next_vals = vals;
        if (WR && ADDR == OFS_CTRL) begin
            next_auto_mode = WDATA[CTRL_AUTO_BIT];
        end
        // value words sit at their payload offsets; writes to 0x00 and 0x08 are ignored
        if (WR && ADDR >= OFS_VAL_FIRST && ADDR <= OFS_VAL_LAST) begin
            next_vals[word_of(ADDR)] = WDATA;
        end
        send_req = (WR && ADDR == OFS_CTRL && WDATA[CTRL_SEND_BIT]) || (auto_mode && second_roll);
        start = send_req && (state == ST_IDLE);
        // sticky flags: a new event in the snapshot cycle survives for the next packet
        next_ev1 = (ev1 && !start) || ev_edge[0];
        next_ev2 = (ev2 && !start) || ev_edge[1];
        next_ovf = (ovf && !start) || (send_req && state == ST_SEND);
        // a packet is frozen whole so a write mid-send cannot tear it
        next_snap = snap;
        if (start) begin
            next_snap[0] = {filter, health};
            next_snap[1] = seconds;
            next_snap[2] = micros;
            for (int w = VAL_FIRST_WORD; w < PAY_WORDS; w++) begin
                next_snap[w] = vals[w];
            end
        end
        // serializer, byte lane picked from the low index bits
        cur_word = snap[idx[6:2]];
        fifo_in.data = cur_word[{idx[1:0], 3'b000} +: 8];
        fifo_in.last = (idx == 7'(PKT_LEN_BYTES - 8'h01));
        fifo_in_valid = (state == ST_SEND);
        next_state = state;
        next_idx = idx;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_SEND;
                    next_idx = 7'h00;
                end
            end
            ST_SEND: begin
                if (fifo_in_ready) begin
                    next_idx = idx + 7'h01;
                    if (fifo_in.last) begin
                        next_state = ST_IDLE;
                    end
                end
            end
        endcase
        next_busy = (next_state == ST_SEND);

        // register reads, unmapped words read zero
        next_rdata = 32'h00000000;
        if (RD) begin
            if (ADDR == OFS_STATUS) begin
                next_rdata = {filter, health};
            end else if (ADDR == OFS_SECONDS) begin
                next_rdata = seconds;
            end else if (ADDR == OFS_MICROS) begin
                next_rdata = micros;
            end else if (ADDR >= OFS_VAL_FIRST && ADDR <= OFS_VAL_LAST && ADDR[1:0] == 2'b00) begin
                next_rdata = vals[word_of(ADDR)];
            end else if (ADDR == OFS_CTRL) begin
                next_rdata[CTRL_AUTO_BIT] = auto_mode;
            end else if (ADDR == OFS_STAT) begin
                next_rdata[STAT_BUSY_BIT] = (state == ST_SEND);
                next_rdata[STAT_OVF_BIT] = ovf;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= ST_IDLE;
            idx <= 7'h00;
            seconds <= 32'h00000000;
            micros <= 32'h00000000;
            tick <= 8'h00;
            auto_mode <= 1'b0;
            ovf <= 1'b0;
            ev1 <= 1'b0;
            ev2 <= 1'b0;
            RDATA <= 32'h00000000;
            BUSY <= 1'b0;
            PKT_ID <= 8'h00;
            PKT_LEN <= 8'h00;
            snap <= '{default: 32'h00000000};
            vals <= '{default: 32'h00000000};
        end else begin
            state <= next_state;
            idx <= next_idx;
            seconds <= next_seconds;
            micros <= next_micros;
            tick <= next_tick;
            auto_mode <= next_auto_mode;
            ovf <= next_ovf;
            ev1 <= next_ev1;
            ev2 <= next_ev2;
            RDATA <= next_rdata;
            BUSY <= next_busy;
            PKT_ID <= PKT_ID_CODE;
            PKT_LEN <= PKT_LEN_BYTES;
            snap <= next_snap;
            vals <= next_vals;
        end
    end

    // ****************************************
    // output fifo; a stalled host holds the serializer
    // ****************************************
    byte_fifo #(
        .WIDTH($bits(tx_byte_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst(SRST),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(TX_VALID),
        .out_ready(TX_READY)
    );

    assign TX_DATA = fifo_out.data;
    assign TX_LAST = fifo_out.last;

endmodule : nav_state_framer

`default_nettype wire

// ==== test/nav_state_framer_sva.sv ====
// checker: port-level assertions for the navigation state packet framer
`timescale 1ns/1ps
`default_nettype none
module nav_state_framer_sva
    import nav_state_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [7:0] PKT_ID,
    input wire logic [7:0] PKT_LEN,
    input wire logic BUSY
);
    // ****************************************
    // byte position tracking
    // ****************************************
    logic [7:0] byte_cnt;
    logic [7:0] next_byte_cnt;
    logic send_req;
    assign send_req = WR && ADDR == OFS_CTRL && WDATA[CTRL_SEND_BIT];
    always_comb begin
        next_byte_cnt = byte_cnt;
        if (TX_VALID && TX_READY) begin
            next_byte_cnt = TX_LAST ? 8'h00 : byte_cnt + 8'h01;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            byte_cnt <= 8'h00;
        end else begin
            byte_cnt <= next_byte_cnt;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    // ****************************************
    // assertions
    // ****************************************
    chk_reset_zero: assert property (disable iff (1'b0) SRST |=> PKT_ID == 8'h00
        && PKT_LEN == 8'h00 && !TX_VALID && !BUSY && RDATA == 32'h0)
        else $error("outputs not cleared by reset");
    chk_id_len: assert property (disable iff (1'b0) !SRST |=> PKT_ID == PKT_ID_CODE
        && PKT_LEN == PKT_LEN_BYTES)
        else $error("packet id or length wrong");
    chk_read_idle: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data outside read answer cycle");
    chk_start_busy: assert property (send_req && !BUSY |=> BUSY)
        else $error("busy did not rise on send");
    chk_first_byte: assert property (send_req && !BUSY && !TX_VALID
        |=> !TX_VALID ##1 !TX_VALID ##1 TX_VALID)
        else $error("first byte not three edges after send");
    chk_tx_hold: assert property (TX_VALID && !TX_READY
        |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
        else $error("stalled byte changed");
    chk_last_pos: assert property (TX_VALID && TX_LAST |-> byte_cnt == 8'h63)
        else $error("last flag not on byte 99");
    chk_quiet_idle: assert property (!BUSY && !TX_VALID |=> !TX_VALID)
        else $error("byte produced without a send");
    chk_micros_max: assert property (RD && ADDR == OFS_MICROS |=> RDATA <= MICROS_MAX)
        else $error("microseconds above limit");
    chk_ovf_stat: assert property (send_req && BUSY ##[1:4] (RD && ADDR == OFS_STAT)
        |=> RDATA[STAT_OVF_BIT])
        else $error("overflow flag missing after dropped send");
    cover property (send_req && !BUSY);
    cover property (send_req && BUSY);
    cover property (TX_VALID && TX_READY && TX_LAST);
    cover property (TX_VALID && !TX_READY && BUSY);
endmodule : nav_state_framer_sva

bind nav_state_framer nav_state_framer_sva #(.FIFO_DEPTH(FIFO_DEPTH)) nav_state_framer_sva_inst (
    .REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .PKT_ID(PKT_ID), .PKT_LEN(PKT_LEN), .BUSY(BUSY)
);
`default_nettype wire

// ==== test/nav_host_model.sv ====
// partner model: host side that accepts and stores state packet bytes
`timescale 1ns/1ps
`default_nettype none
module nav_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic hold,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready
);
    // ****************************************
    // byte sink
    // ****************************************
    logic [7:0] pkt [0:99];
    logic [7:0] idx;
    logic [1:0] phase;
    int n_pkts;
    int last_len;
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ready <= 1'b0;
            idx <= 8'h00;
            phase <= 2'h0;
            n_pkts <= 0;
            last_len <= 0;
        end else begin
            phase <= phase + 2'h1;
            // a slow host takes one byte in four, hold stalls outright to fill the fifo
            tx_ready <= !hold && (!slow || phase == 2'h3);
            if (tx_valid && tx_ready) begin
                if (idx < 8'h64) begin
                    pkt[idx] <= tx_data;
                end
                idx <= tx_last ? 8'h00 : idx + 8'h01;
                if (tx_last) begin
                    n_pkts <= n_pkts + 1;
                    last_len <= int'(idx) + 1;
                end
            end
        end
    end
endmodule : nav_host_model
`default_nettype wire

// ==== test/tb.sv ====
// testbench: registers, status mapping and packet stream of the state packet framer
`timescale 1ns/1ps
`default_nettype none
module tb
    import nav_state_pkg::*;
;
    logic REF_CLK, SRST, WR, RD, EVENT1, EVENT2, TX_LAST, TX_VALID, TX_READY, BUSY, slow, hold;
    logic [7:0] ADDR, TX_DATA, PKT_ID, PKT_LEN;
    logic [31:0] WDATA, RDATA, rv;
    sense_t SENSE;
    nav_flags_t NAV;
    fix_t FIX;
    int n_fail, checks_done;

    nav_state_framer #(.FIFO_DEPTH(32)) nav_state_framer_inst (
        .REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SENSE(SENSE), .NAV(NAV), .FIX(FIX), .EVENT1(EVENT1), .EVENT2(EVENT2),
        .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .PKT_ID(PKT_ID), .PKT_LEN(PKT_LEN), .BUSY(BUSY));
    nav_host_model nav_host_model_inst (.clk(REF_CLK), .rst(SRST), .slow(slow), .hold(hold),
        .tx_data(TX_DATA), .tx_last(TX_LAST), .tx_valid(TX_VALID), .tx_ready(TX_READY));

    always #50 REF_CLK = ~REF_CLK;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
        @(posedge REF_CLK);
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        d = RDATA;
        @(posedge REF_CLK);
    endtask : rd

    function automatic logic [31:0] vw(input int w);
        return {8'hA0 + 8'(w), 8'h5A, 8'(w), 8'hC3};
    endfunction : vw

    function automatic logic [31:0] pkt_word(input int w);
        return {nav_host_model_inst.pkt[4*w+3], nav_host_model_inst.pkt[4*w+2],
                nav_host_model_inst.pkt[4*w+1], nav_host_model_inst.pkt[4*w]};
    endfunction : pkt_word

    task automatic wait_pkt(input int n);
        for (int k = 0; k < 2000 && nav_host_model_inst.n_pkts < n; k++) begin
            @(posedge REF_CLK);
        end
        check(nav_host_model_inst.n_pkts, n);
    endtask : wait_pkt

    task automatic verify(input logic [15:0] h, input logic [15:0] f);
        check(pkt_word(0), {f, h});
        check(pkt_word(1), 32'h60000001);
        check(32'(pkt_word(2) > MICROS_MAX), 32'h0);
        for (int w = 3; w < 25; w++) begin
            check(pkt_word(w), vw(w));
        end
        check(nav_host_model_inst.last_len, 32'h64);
    endtask : verify

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset;
        @(negedge REF_CLK);
        check({24'h0, PKT_ID}, 32'h14);
        check({24'h0, PKT_LEN}, 32'h64);
        @(posedge REF_CLK);
        rd(OFS_SECONDS, rv);
        check(rv, 32'h0);
        $display("reset test done");
    endtask : test_reset

    task automatic test_regs;
        for (int w = 3; w < 25; w++) begin
            wr(8'(4 * w), vw(w));
        end
        rd(OFS_ACCEL_X, rv);
        check(rv, vw(12));
        rd(OFS_GFORCE, rv);
        check(rv, vw(15));
        rd(OFS_RATE_Z, rv);
        check(rv, vw(21));
        rd(OFS_SD_LAT, rv);
        check(rv, vw(22));
        wr(OFS_SECONDS, 32'h60000001);
        rd(OFS_SECONDS, rv);
        check(rv, 32'h60000001);
        wr(OFS_STATUS, 32'hFFFFFFFF);
        rd(OFS_STATUS, rv);
        check(rv, 32'h0);
        wr(OFS_CTRL, 32'h2);
        rd(OFS_CTRL, rv);
        check(rv, 32'h2);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_MICROS, rv);
        check(32'(rv > MICROS_MAX), 32'h0);
        rd(8'hC0, rv);
        check(rv, 32'h0);
        $display("register test done");
    endtask : test_regs

    task automatic test_status;
        for (int i = 0; i < 18; i++) begin
            SENSE <= sense_t'(18'h1 << i);
            repeat (4) @(posedge REF_CLK);
            rd(OFS_STATUS, rv);
            check(rv, 32'h1 << (i < 4 ? 14 : 17 - i));
        end
        SENSE <= '0;
        for (int i = 0; i < 11; i++) begin
            NAV <= nav_flags_t'(11'h1 << i);
            repeat (4) @(posedge REF_CLK);
            rd(OFS_STATUS, rv);
            check(rv, 32'h10000 << (i < 7 ? 15 - i : 10 - i));
        end
        NAV <= '0;
        for (int f = 0; f < 8; f++) begin
            FIX <= fix_t'(f);
            repeat (4) @(posedge REF_CLK);
            rd(OFS_STATUS, rv);
            check(rv, 32'(f) << 20);
        end
        $display("status mapping test done");
    endtask : test_status

    task automatic test_packets;
        SENSE <= sense_t'(18'h20001);
        NAV <= nav_flags_t'(11'h421);
        FIX <= FIX_RTK_FLOAT;
        EVENT1 <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        EVENT1 <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        wr(OFS_CTRL, 32'h1);
        wait_pkt(1);
        verify(16'h4001, 16'h84E1);
        EVENT2 <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        EVENT2 <= 1'b0;
        hold <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_STAT, rv);
        check(rv, 32'h3);
        repeat (60) @(negedge REF_CLK);
        check({31'h0, BUSY}, 32'h1);
        @(posedge REF_CLK);
        hold <= 1'b0;
        slow <= 1'b1;
        wait_pkt(2);
        verify(16'h4001, 16'h8561);
        slow <= 1'b0;
        wr(OFS_CTRL, 32'h1);
        wait_pkt(3);
        verify(16'hC001, 16'h8461);
        @(negedge REF_CLK);
        check({31'h0, TX_VALID}, 32'h0);
        @(posedge REF_CLK);
        rd(OFS_STAT, rv);
        check(rv, 32'h0);
        $display("packet stream test done");
    endtask : test_packets

    initial begin
        REF_CLK = 1'b0;
        SRST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        SENSE = '0;
        NAV = '0;
        FIX = FIX_NONE;
        EVENT1 = 1'b0;
        EVENT2 = 1'b0;
        slow = 1'b0;
        hold = 1'b0;
        n_fail = 0;
        checks_done = 0;
        repeat (2) @(posedge REF_CLK);
        SRST <= 1'b0;
        @(posedge REF_CLK);
        test_reset();
        test_regs();
        test_status();
        test_packets();
        finish_test();
    end

    initial begin : watchdog
        repeat (50000) @(posedge REF_CLK);
        n_fail++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
